// ==== shared/power_pulse_pkg.sv ====
package power_pulse_pkg;
	// sample and arithmetic widths
	localparam int SAMPLE_W = 16;
	localparam int PROD_W = 36;
	localparam int ACC_W = 40;
	// master clock and sample rate
	localparam longint CLOCK_HZ = 40000000;
	localparam longint SAMPLE_HZ = 900000;
	localparam int SAMPLE_DIV = int'(CLOCK_HZ / SAMPLE_HZ);
	localparam logic [7:0] SAMPLE_DIV_M1 = 8'(SAMPLE_DIV - 1);
	// input bandwidth at the reference master clock, scales with the clock
	localparam longint BW_REF_HZ = 14000;
	localparam longint MCLK_REF_HZ = 3579500;
	localparam longint BW_HZ = BW_REF_HZ * CLOCK_HZ / MCLK_REF_HZ;
	// gain codes
	localparam logic [1:0] GAIN_X1 = 2'h0;
	localparam logic [1:0] GAIN_X2 = 2'h1;
	localparam logic [1:0] GAIN_X8 = 2'h2;
	localparam logic [1:0] GAIN_X16 = 2'h3;
	// filter shifts: hpf corner near 140 Hz at 900 kHz, lpf shift sets 8.7 Hz corner at 900 kHz
	localparam int HPF_SHIFT = 10;
	localparam int LPF_SHIFT = 14;
	localparam int PHASE_SHIFT = 4;
	// pulse thresholds: slow = 2048 * calibration at rate code 0, halved for each rate code step
	localparam int CAL_THRESH_LOG2 = 26;
	localparam int SLOW_RATIO_LOG2 = 11;
	localparam int PULSE_LEN = 8;
	// supply monitor
	localparam logic [11:0] SUPPLY_TRIP_4V = 12'hCCC;
	localparam logic [11:0] SUPPLY_HYST = 12'h040;
	localparam int SUPPLY_FILT = 64;
endpackage : power_pulse_pkg

// ==== logic/power_pulse_path.sv ====
`timescale 1ns/1ps
// Functional notes
// RQ1 - current channel is scaled by 1, 2, 8 or 16 according to the two gain select inputs.
// RQ2 - with high-pass enable high the current channel loses its dc offset before the multiplier.
// RQ3 - phase compensation of the current channel is active only while the high-pass filter is on, matched to 1 kHz.
// RQ4 - the path is held in reset while the analog supply is below 4 V, with hysteresis and filtering.
// RQ5 - the product is low-pass filtered with a first-order response cornered at 8.9 Hz; the shift of 14 gives about 8.7 Hz at 900 kHz.
// RQ6 - the filtered power is integrated over time to form the pulse frequency.
// RQ7 - the calibration output runs up to 2048 times the slow outputs from a shorter accumulation.
// RQ8 - the two slow outputs come from a much longer accumulation and are nearly ripple free.
// RQ9 - the external counter should average the calibration pulse frequency over time.
// RQ10 - input bandwidth is 14 kHz at 3.5795 MHz master clock and scales with the clock.
// RQ11 - each slow output pulse is active low.
// RQ12 - the rate select inputs choose one of four base frequencies, binary fractions of the clock.
// RQ13 - both channels arrive as 900 kHz converter samples and all processing is digital.
// RQ14 - each pulse generator accumulates every sample and pulses on threshold crossing, keeping the remainder.
module power_pulse_path
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// converter samples
	input wire logic signed [power_pulse_pkg::SAMPLE_W-1:0] i_current_sample,
	input wire logic signed [power_pulse_pkg::SAMPLE_W-1:0] i_voltage_sample,
	// supply level, full scale 12 bits
	input wire logic [11:0] i_analog_supply,
	// configuration pins
	input wire logic i_gain_select_low,
	input wire logic i_gain_select_high,
	input wire logic i_highpass_enable_pin,
	input wire logic i_rate_select_low,
	input wire logic i_rate_select_high,
	// pulse outputs and supply ok flag
	output logic o_slow_pulse_out_a_n,
	output logic o_slow_pulse_out_b_n,
	output logic o_calibration_pulse_out,
	output logic o_supply_ok
);
	import power_pulse_pkg::*;

	logic [7:0] div_ff;
	logic strobe_ff;
	logic [6:0] filt_ff;
	logic ok_ff;
	// wide enough to hold the dc estimate scaled up by the leak
	logic signed [SAMPLE_W+4+HPF_SHIFT:0] hpf_acc_ff;
	logic signed [SAMPLE_W+4:0] cur_ff;
	logic signed [SAMPLE_W+4:0] phase_ff;
	logic signed [PROD_W-1:0] lpf_ff;
	logic signed [ACC_W-1:0] cal_acc_ff;
	logic signed [ACC_W-1:0] slow_acc_ff;
	logic [3:0] cal_len_ff;
	logic [3:0] slow_len_ff;
	logic slow_sel_ff;
	logic cal_ff;
	logic slow_a_ff;
	logic slow_b_ff;

	wire run = ok_ff && !i_reset;
	// supply monitor with hysteresis: trip low, release higher
	wire supply_low = i_analog_supply < SUPPLY_TRIP_4V; // RQ4
	wire supply_high = i_analog_supply >= (SUPPLY_TRIP_4V + SUPPLY_HYST); // RQ4
	wire [1:0] gain_code = {i_gain_select_high, i_gain_select_low};
	wire [1:0] rate_code = {i_rate_select_high, i_rate_select_low};
	wire signed [SAMPLE_W+4:0] cur_ext = {{5{i_current_sample[SAMPLE_W-1]}}, i_current_sample};
	wire signed [SAMPLE_W+4:0] cur_gain =
		(gain_code == GAIN_X1) ? cur_ext :
		(gain_code == GAIN_X2) ? (cur_ext <<< 1) :
		(gain_code == GAIN_X8) ? (cur_ext <<< 3) : (cur_ext <<< 4); // RQ1
	// hpf: subtract a leaky dc estimate
	wire signed [SAMPLE_W+4:0] dc_est = hpf_acc_ff[SAMPLE_W+4+HPF_SHIFT:HPF_SHIFT];
	wire signed [SAMPLE_W+4:0] cur_hp = cur_gain - dc_est; // RQ2
	// phase trim: small lag blend cancels hpf lead, only with hpf on
	wire signed [SAMPLE_W+4:0] cur_pc = cur_hp - ((cur_hp - phase_ff) >>> PHASE_SHIFT); // RQ3
	wire signed [SAMPLE_W+4:0] cur_sel = i_highpass_enable_pin ? cur_pc : cur_gain; // RQ2 RQ3
	wire signed [PROD_W-1:0] product = PROD_W'(cur_ff * $signed(i_voltage_sample)); // RQ13
	wire signed [PROD_W-1:0] lpf_next = lpf_ff + ((product - lpf_ff) >>> LPF_SHIFT); // RQ5
	wire signed [ACC_W-1:0] power = ACC_W'(lpf_ff);
	// thresholds: lower base rate gives longer slow accumulation
	wire signed [ACC_W-1:0] cal_thresh = ACC_W'(1) <<< CAL_THRESH_LOG2;
	wire signed [ACC_W-1:0] slow_thresh = cal_thresh <<< (SLOW_RATIO_LOG2 - 32'(rate_code)); // RQ12 RQ8
	wire signed [ACC_W-1:0] cal_sum = cal_acc_ff + power; // RQ6
	wire signed [ACC_W-1:0] slow_sum = slow_acc_ff + power; // RQ6
	wire cal_hit = cal_sum >= cal_thresh; // RQ14 RQ7
	wire slow_hit = slow_sum >= slow_thresh; // RQ14 RQ8
	// floor at zero: reverse power would otherwise wrap the sum into false pulses
	wire signed [ACC_W-1:0] cal_next =
		cal_hit ? cal_sum - cal_thresh : (cal_sum[ACC_W-1] ? {ACC_W{1'b0}} : cal_sum); // RQ14
	wire signed [ACC_W-1:0] slow_next =
		slow_hit ? slow_sum - slow_thresh : (slow_sum[ACC_W-1] ? {ACC_W{1'b0}} : slow_sum); // RQ14

	always_ff @(posedge i_clock)
	begin
		if (i_reset || div_ff == SAMPLE_DIV_M1)
			div_ff <= 8'h00;
		else
			div_ff <= div_ff + 8'h01;
		// sample rate follows the clock, so the input bandwidth scales with it
		strobe_ff <= !i_reset && div_ff == SAMPLE_DIV_M1; // RQ13 RQ10
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			filt_ff <= 7'h00;
			ok_ff <= 1'b0;
		end
		else if (ok_ff ? supply_low : supply_high)
		begin
			filt_ff <= filt_ff + 7'h01;
			if (filt_ff == 7'(SUPPLY_FILT - 1))
			begin
				ok_ff <= !ok_ff; // RQ4
				filt_ff <= 7'h00;
			end
		end
		else
			filt_ff <= 7'h00;
	end

	always_ff @(posedge i_clock)
	begin
		if (!run)
		begin
			hpf_acc_ff <= '0;
			cur_ff <= '0;
			phase_ff <= '0;
			lpf_ff <= '0;
		end
		else if (strobe_ff)
		begin
			hpf_acc_ff <= hpf_acc_ff + cur_hp; // RQ2
			phase_ff <= cur_hp;
			cur_ff <= cur_sel;
			lpf_ff <= lpf_next; // RQ5
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!run)
		begin
			cal_acc_ff <= '0;
			slow_acc_ff <= '0;
			cal_len_ff <= 4'h0;
			slow_len_ff <= 4'h0;
			slow_sel_ff <= 1'b0;
		end
		else
		begin
			// one pulse per sample at most; heavier power stays in the remainder
			if (strobe_ff)
				cal_acc_ff <= cal_next; // RQ14
			if (strobe_ff)
				slow_acc_ff <= slow_next; // RQ14
			if (strobe_ff && cal_hit)
				cal_len_ff <= 4'(PULSE_LEN);
			else if (cal_len_ff != 4'h0)
				cal_len_ff <= cal_len_ff - 4'h1;
			if (strobe_ff && slow_hit)
			begin
				slow_len_ff <= 4'(PULSE_LEN);
				slow_sel_ff <= !slow_sel_ff;
			end
			else if (slow_len_ff != 4'h0)
				slow_len_ff <= slow_len_ff - 4'h1;
		end
	end

	// outputs from flops; slow pulses alternate a/b for stepper drive
	always_ff @(posedge i_clock)
	begin
		cal_ff <= run && cal_len_ff != 4'h0;
		slow_a_ff <= !(run && slow_len_ff != 4'h0 && slow_sel_ff); // RQ11
		slow_b_ff <= !(run && slow_len_ff != 4'h0 && !slow_sel_ff); // RQ11
	end

	assign o_calibration_pulse_out = cal_ff;
	assign o_slow_pulse_out_a_n = slow_a_ff;
	assign o_slow_pulse_out_b_n = slow_b_ff;
	assign o_supply_ok = ok_ff;

	AST_SLOW_IDLE_HIGH: assert property (@(posedge i_clock) disable iff (i_reset) // RQ4
		!ok_ff |=> o_slow_pulse_out_a_n && o_slow_pulse_out_b_n) else $error("slow out active in reset");
	AST_NO_CAL_LOW_SUPPLY: assert property (@(posedge i_clock) disable iff (i_reset) // RQ4
		!ok_ff |=> !o_calibration_pulse_out) else $error("cal pulse while supply low");
	// a supply drop right after the hit cancels the pulse, so the run must last one more edge
	AST_CAL_PULSE: assert property (@(posedge i_clock) disable iff (i_reset) // RQ7
		run && strobe_ff && cal_hit ##1 run
		|=> o_calibration_pulse_out) else $error("cal pulse missing");
	AST_SLOW_PULSE: assert property (@(posedge i_clock) disable iff (i_reset) // RQ11
		run && strobe_ff && slow_hit ##1 run
		|=> (!o_slow_pulse_out_a_n || !o_slow_pulse_out_b_n))
		else $error("slow pulse missing");
	AST_CAL_WIDTH: assert property (@(posedge i_clock) disable iff (i_reset || !ok_ff) // RQ7
		$rose(o_calibration_pulse_out) |-> o_calibration_pulse_out [*8] ##1 !o_calibration_pulse_out)
		else $error("cal pulse width wrong");
	AST_SLOW_WIDTH: assert property (@(posedge i_clock) disable iff (i_reset || !ok_ff) // RQ11
		$fell(o_slow_pulse_out_a_n) |-> !o_slow_pulse_out_a_n [*8] ##1 o_slow_pulse_out_a_n)
		else $error("slow pulse width wrong");
	AST_SLOW_EXCL: assert property (@(posedge i_clock) disable iff (i_reset) // RQ8
		o_slow_pulse_out_a_n || o_slow_pulse_out_b_n) else $error("both slow outputs low");
	AST_REMAINDER: assert property (@(posedge i_clock) disable iff (i_reset) // RQ14
		run && strobe_ff && cal_hit |=> cal_acc_ff == $past(cal_sum) - $past(cal_thresh))
		else $error("remainder lost");
	AST_ACC_FLOOR: assert property (@(posedge i_clock) disable iff (i_reset) // RQ14
		run && strobe_ff |=> !cal_acc_ff[ACC_W-1] && !slow_acc_ff[ACC_W-1]) else $error("accumulator negative");
	AST_STROBE_RATE: assert property (@(posedge i_clock) disable iff (i_reset) // RQ13 RQ10
		strobe_ff |=> !strobe_ff ##43 strobe_ff) else $error("sample strobe period wrong");
	AST_HPF_BYPASS: assert property (@(posedge i_clock) disable iff (i_reset) // RQ2
		run && strobe_ff && !i_highpass_enable_pin |=> cur_ff == $past(cur_gain)) else $error("hpf not bypassed");
	AST_GAIN1: assert property (@(posedge i_clock) // RQ1
		gain_code == GAIN_X1 |-> cur_gain == i_current_sample) else $error("gain 1 wrong");
	AST_GAIN2: assert property (@(posedge i_clock) // RQ1
		gain_code == GAIN_X2 |-> cur_gain == i_current_sample * 2) else $error("gain 2 wrong");
	AST_GAIN8: assert property (@(posedge i_clock) // RQ1
		gain_code == GAIN_X8 |-> cur_gain == i_current_sample * 8) else $error("gain 8 wrong");
	AST_GAIN16: assert property (@(posedge i_clock) // RQ1
		gain_code == GAIN_X16 |-> cur_gain == i_current_sample * 16) else $error("gain 16 wrong");
	COV_CAL: cover property (@(posedge i_clock) o_calibration_pulse_out);
	COV_SLOW_A: cover property (@(posedge i_clock) !o_slow_pulse_out_a_n);
	COV_SLOW_B: cover property (@(posedge i_clock) !o_slow_pulse_out_b_n);
	COV_HPF_SAMPLE: cover property (@(posedge i_clock) run && strobe_ff && i_highpass_enable_pin);
	COV_SUPPLY_UP: cover property (@(posedge i_clock) $rose(ok_ff));
endmodule : power_pulse_path

// ==== verification/pulse_counter.sv ====
`timescale 1ns/1ps
// far side: tallies pulses, checks slow width and a/b order
module pulse_counter
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset,
	// meter pulses
	input wire logic i_cal,
	input wire logic i_slow_a_n,
	input wire logic i_slow_b_n,
	// tallies
	output int o_cal_count,
	output int o_slow_count,
	output int o_bad_count
);
	logic cal_ff, a_ff, b_ff, last_a_ff;
	int low_ff;
	wire a_fall = a_ff && !i_slow_a_n;
	wire b_fall = b_ff && !i_slow_b_n;
	wire short = ((!a_ff && i_slow_a_n) || (!b_ff && i_slow_b_n)) && low_ff != 8;
	always_ff @(posedge i_clock)
	begin
		cal_ff <= i_cal;
		a_ff <= i_slow_a_n;
		b_ff <= i_slow_b_n;
		low_ff <= (i_slow_a_n && i_slow_b_n) ? 0 : low_ff + 1;
		if (i_reset)
		begin
			o_cal_count <= 0;
			o_slow_count <= 0;
			o_bad_count <= 0;
			last_a_ff <= 1'b0;
		end
		else
		begin
			// counting over a window is what removes the ripple
			o_cal_count <= o_cal_count + int'(i_cal && !cal_ff);
			o_slow_count <= o_slow_count + int'(a_fall) + int'(b_fall);
			o_bad_count <= o_bad_count + int'(short) + int'(a_fall && last_a_ff) + int'(b_fall && !last_a_ff);
			if (a_fall || b_fall)
				last_a_ff <= a_fall;
		end
	end
endmodule : pulse_counter

// ==== verification/tb_energy_power_to_pulse_path.sv ====
`timescale 1ns/1ps
module tb_energy_power_to_pulse_path;
	import power_pulse_pkg::*;
	logic i_clock, i_reset, hpf, a_n, b_n, cal, ok;
	logic [1:0] gain, rate;
	logic [11:0] supply;
	logic [15:0] cur, volt;
	int n_fail, n_compared, cal_n, slow_n, bad_n, prev;
	power_pulse_path u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_current_sample(cur),
		.i_voltage_sample(volt), .i_analog_supply(supply), .i_gain_select_low(gain[0]),
		.i_gain_select_high(gain[1]), .i_highpass_enable_pin(hpf), .i_rate_select_low(rate[0]),
		.i_rate_select_high(rate[1]), .o_slow_pulse_out_a_n(a_n), .o_slow_pulse_out_b_n(b_n),
		.o_calibration_pulse_out(cal), .o_supply_ok(ok));
	pulse_counter u_far (.i_clock(i_clock), .i_reset(i_reset), .i_cal(cal), .i_slow_a_n(a_n),
		.i_slow_b_n(b_n), .o_cal_count(cal_n), .o_slow_count(slow_n), .o_bad_count(bad_n));
	task end_of_test;
		if (n_fail == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check
	// restart at the release level, so the supply filter is timed too
	task run(input logic [1:0] g, input logic h, input logic [1:0] r, input logic [15:0] c, input logic [15:0] v,
		input int n);
		@(posedge i_clock);
		i_reset <= 1'b1;
		gain <= g;
		hpf <= h;
		rate <= r;
		cur <= c;
		volt <= v;
		supply <= 12'hD0C;
		repeat (5) @(posedge i_clock);
		i_reset <= 1'b0;
		repeat (60) @(posedge i_clock);
		check(ok, 1'b0);
		repeat (12) @(posedge i_clock);
		check(ok, 1'b1);
		repeat (n) @(posedge i_clock);
	endtask : run
	// eighth-scale current keeps every code below one pulse per sample
	task sc_gain;
		prev = 0;
		for (int g = 0; g < 4; g++)
		begin
			run(2'(g), 1'b0, 2'h0, 16'h1000, 16'h7FFF, 10000);
			check(32'(cal_n > prev), 32'h1);
			prev = cal_n;
		end
	endtask : sc_gain
	task sc_highpass;
		run(2'h3, 1'b1, 2'h0, 16'h1000, 16'h7FFF, 10000);
		check(32'(cal_n < prev), 32'h1);
	endtask : sc_highpass
	task sc_negative;
		run(2'h3, 1'b0, 2'h0, 16'hF000, 16'h7FFF, 5000);
		check(32'(cal_n + slow_n), 32'h0);
		// reverse power from the voltage side as well
		run(2'h3, 1'b0, 2'h0, 16'h1000, 16'h8001, 3000);
		check(32'(cal_n + slow_n), 32'h0);
	endtask : sc_negative
	task sc_slow_and_supply;
		run(2'h3, 1'b0, 2'h3, 16'h7FFF, 16'h7FFF, 30000);
		check(32'(slow_n > 0), 32'h1);
		check(32'(bad_n), 32'h0);
		check(32'(cal_n > slow_n), 32'h1);
		supply <= 12'hCCC;
		repeat (72) @(posedge i_clock);
		check(ok, 1'b1);
		supply <= 12'hCCB;
		repeat (72) @(posedge i_clock);
		check(ok, 1'b0);
		prev = cal_n;
		repeat (500) @(posedge i_clock);
		check(32'(cal_n - prev), 32'h0);
		check({a_n, b_n, cal}, 3'b110);
	endtask : sc_slow_and_supply
	initial
	begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	initial
	begin
		#(95000 * 25);
		n_fail++;
		end_of_test();
	end
	initial
	begin
		i_reset = 1'b1;
		gain = 2'h0;
		hpf = 1'b0;
		rate = 2'h0;
		cur = 16'h0000;
		volt = 16'h7FFF;
		supply = 12'h000;
		n_fail = 0;
		n_compared = 0;
		sc_gain();
		sc_highpass();
		sc_negative();
		sc_slow_and_supply();
		end_of_test();
	end
endmodule : tb_energy_power_to_pulse_path
